// ==== hdl/swt_defs.vh ====
// Register map, field positions and timing constants for the system watchdog
`ifndef SWT_DEFS_VH
`define SWT_DEFS_VH
// Register indices; byte address on the bus = index * 4
`define SWT_IDX_UNIT 8'h52
`define SWT_IDX_COUNT 8'h53
`define SWT_IDX_RELOAD 8'h54
`define SWT_IDX_CTRL 8'h55
`define SWT_IDX_IRQ_STAT 8'h60
`define SWT_IDX_IRQ_MASK 8'h61
`define SWT_ADDR_BITS 10
// Field positions
`define SWT_UNIT_SEC_BIT 7
`define SWT_SRC_GAME_BIT 0
`define SWT_SRC_KBD_BIT 1
`define SWT_SRC_MOUSE_BIT 2
`define SWT_MAP_HI 7
`define SWT_MAP_LO 4
`define SWT_CTRL_STATUS_BIT 0
`define SWT_CTRL_FORCE_BIT 2
// Reset values
`define SWT_RST_UNIT 8'h00
`define SWT_RST_COUNT 8'h00
`define SWT_RST_RELOAD 8'h00
// Game port address, invalid mapping
`define SWT_GAME_PORT 16'h0201
`define SWT_MAP_INVALID 4'h2
// Timing
`define SWT_CLK_HZ 200000000
`define SWT_SECOND_S 1
`define SWT_MINUTE_S 60
`define SWT_SEC_CYCLES (`SWT_CLK_HZ * `SWT_SECOND_S)
`endif

// ==== hdl/swt_tick.v ====
// Divider that makes the one-second and one-minute ticks
`timescale 1ns/10ps
`default_nettype none
`include "swt_defs.vh"
module swt_tick #(
    parameter SEC_CYCLES = `SWT_SEC_CYCLES,
    parameter SEC_PER_MIN = `SWT_MINUTE_S
) (
    input wire clk,
    input wire rstn,
    input wire restart,
    output reg sec_tick,
    output reg min_tick
);
    reg [31:0] cyc;
    reg [7:0] secs;
    // Restart aligns the prescaler so a fresh count gets full units
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cyc <= 32'h0;
            secs <= 8'h0;
            sec_tick <= 1'b0;
            min_tick <= 1'b0;
        end
        else if (restart)
        begin
            cyc <= 32'h0;
            secs <= 8'h0;
            sec_tick <= 1'b0;
            min_tick <= 1'b0;
        end
        else
        begin
            sec_tick <= 1'b0;
            min_tick <= 1'b0;
            if (cyc == SEC_CYCLES - 1)
            begin
                cyc <= 32'h0;
                sec_tick <= 1'b1;
                if (secs == SEC_PER_MIN - 1)
                begin
                    secs <= 8'h0;
                    min_tick <= 1'b1;
                end
                else
                    secs <= secs + 8'h1;
            end
            else
                cyc <= cyc + 32'h1;
        end
    end
endmodule // swt_tick
`default_nettype wire

// ==== hdl/swt_watchdog.v ====
// System watchdog timer with classic Wishbone register slave
// How it works
// RULE1: The count runs in minutes when the unit-select bit is 0 and in seconds when it is 1.
// RULE2: A zero timeout count keeps the watchdog disabled so no timeout occurs; the code still times out on a force write.
// RULE3: The timeout count is plain binary, N units for N from 1 to 255.
// RULE4: With the game-port bit set an I/O access to the joystick address restarts the count.
// RULE5: With the keyboard bit set a keyboard interrupt restarts the count.
// RULE6: With the mouse bit set a mouse interrupt restarts the count.
// RULE7: The timeout interrupt goes to the IRQ in the upper config nibble, zero means none; the code also drives no line for mapping 2.
// RULE8: A status bit is set on timeout and stays set while counting until software writes it.
// RULE9: Writing 1 to the force bit makes an immediate timeout and the bit self-clears.
// RULE10: The counter reloads on a count write or a reload event and times out on expiry.
`timescale 1ns/10ps
`default_nettype none
`include "swt_defs.vh"
module swt_watchdog #(
    parameter SEC_CYCLES = `SWT_SEC_CYCLES
) (
    input wire clk,
    input wire rstn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire io_strobe,
    input wire [15:0] io_addr,
    input wire kbd_irq,
    input wire mouse_irq,
    output reg [15:0] irq_lines,
    output reg timeout_pulse,
    output reg irq
);
    reg [7:0] unit_select;
    reg [7:0] timeout_count;
    reg [7:0] reload_sources;
    reg status;
    reg [7:0] remaining;
    reg active;
    reg irq_stat;
    reg irq_mask;
    reg [2:0] io_s1;
    reg [2:0] io_s2;
    reg [2:0] io_prev;
    reg [15:0] addr_s1;
    reg [15:0] addr_s2;
    wire [2:0] edges;
    wire sec_tick;
    wire min_tick;
    wire unit_tick;
    wire bus_req;
    wire [7:0] idx;
    wire wr;
    wire [7:0] wbyte;
    wire count_wr;
    wire force_wr;
    wire reload_evt;
    wire expire;
    wire timeout_evt;
    wire [3:0] irq_map;
    // Asynchronous activity inputs pass a two-stage synchroniser
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            io_s1 <= 3'h0;
            io_s2 <= 3'h0;
            io_prev <= 3'h0;
            addr_s1 <= 16'h0;
            addr_s2 <= 16'h0;
        end
        else
        begin
            io_s1 <= {mouse_irq, kbd_irq, io_strobe};
            io_s2 <= io_s1;
            io_prev <= io_s2;
            addr_s1 <= io_addr;
            addr_s2 <= addr_s1;
        end
    end
    // Rising edges so a held interrupt restarts only once
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_edge
            assign edges[gi] = io_s2[gi] & ~io_prev[gi];
        end
    endgenerate
    // Address must be stable around the strobe; it passes the same two stages as the strobe
    assign reload_evt = (edges[0] & reload_sources[`SWT_SRC_GAME_BIT]
                         & (addr_s2 == `SWT_GAME_PORT)) // RULE4
                      | (edges[1] & reload_sources[`SWT_SRC_KBD_BIT]) // RULE5
                      | (edges[2] & reload_sources[`SWT_SRC_MOUSE_BIT]); // RULE6
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign idx = wb_adr_i[`SWT_ADDR_BITS-1:2];
    assign wr = bus_req & wb_we_i & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign count_wr = wr & (idx == `SWT_IDX_COUNT);
    assign force_wr = wr & (idx == `SWT_IDX_CTRL) & wbyte[`SWT_CTRL_FORCE_BIT]; // RULE9
    assign unit_tick = unit_select[`SWT_UNIT_SEC_BIT] ? sec_tick : min_tick; // RULE1
    assign expire = active & unit_tick & (remaining == 8'h01); // RULE10
    assign timeout_evt = expire | force_wr; // RULE9
    assign irq_map = reload_sources[`SWT_MAP_HI:`SWT_MAP_LO];
    swt_tick #(
        .SEC_CYCLES(SEC_CYCLES),
        .SEC_PER_MIN(`SWT_MINUTE_S)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .restart(count_wr | reload_evt),
        .sec_tick(sec_tick),
        .min_tick(min_tick)
    );
    // Register writes
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            unit_select <= `SWT_RST_UNIT;
            timeout_count <= `SWT_RST_COUNT;
            reload_sources <= `SWT_RST_RELOAD;
            irq_mask <= 1'b0;
        end
        else if (wr)
        begin
            case (idx)
                `SWT_IDX_UNIT: unit_select <= wbyte & 8'h80;
                `SWT_IDX_COUNT: timeout_count <= wbyte;
                `SWT_IDX_RELOAD: reload_sources <= wbyte & 8'hF7;
                `SWT_IDX_IRQ_MASK: irq_mask <= wbyte[0];
                default: ;
            endcase
        end
    end
    // Counter: reload on write or activity, count down per unit
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            remaining <= 8'h00;
            active <= 1'b0;
        end
        else if (count_wr)
        begin
            remaining <= wbyte; // RULE3
            active <= (wbyte != 8'h00); // RULE2
        end
        else if (timeout_count == 8'h00)
            active <= 1'b0; // RULE2
        else if (reload_evt)
        begin
            remaining <= timeout_count; // RULE10
            active <= 1'b1;
        end
        else if (expire)
            active <= 1'b0;
        else if (active & unit_tick)
            remaining <= remaining - 8'h01; // RULE3
    end
    // Status: hardware set wins over a software write in the same cycle
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            status <= 1'b0;
        else if (timeout_evt)
            status <= 1'b1; // RULE8
        else if (wr & (idx == `SWT_IDX_CTRL))
            status <= wbyte[`SWT_CTRL_STATUS_BIT]; // RULE8
    end
    // Sticky interrupt status, write one to clear; set wins
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            irq_stat <= 1'b0;
        else if (timeout_evt)
            irq_stat <= 1'b1;
        else if (wr & (idx == `SWT_IDX_IRQ_STAT) & wbyte[0])
            irq_stat <= 1'b0;
    end
    // Outputs straight from flops
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq <= 1'b0;
            irq_lines <= 16'h0;
            timeout_pulse <= 1'b0;
        end
        else
        begin
            irq <= irq_stat & irq_mask;
            timeout_pulse <= timeout_evt;
            // Invalid and zero mappings drive nothing
            if (irq_map == 4'h0 || irq_map == `SWT_MAP_INVALID)
                irq_lines <= 16'h0; // RULE7
            else
                irq_lines <= {15'h0, status} << irq_map; // RULE7
        end
    end
    // Wishbone slave: ack one cycle after the request, unmapped reads zero
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req & ~wb_we_i)
            begin
                case (idx)
                    `SWT_IDX_UNIT: wb_dat_o <= {24'h0, unit_select};
                    `SWT_IDX_COUNT: wb_dat_o <= {24'h0, timeout_count};
                    `SWT_IDX_RELOAD: wb_dat_o <= {24'h0, reload_sources};
                    `SWT_IDX_CTRL: wb_dat_o <= {31'h0, status}; // RULE8
                    `SWT_IDX_IRQ_STAT: wb_dat_o <= {31'h0, irq_stat};
                    `SWT_IDX_IRQ_MASK: wb_dat_o <= {31'h0, irq_mask};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule // swt_watchdog
`default_nettype wire

// ==== verification/swt_watchdog_chk.sv ====
// Port-level assertion checker for the system watchdog
`timescale 1ns/10ps
`default_nettype none
module swt_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [15:0] irq_lines,
    input wire logic timeout_pulse,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr = take && wb_we_i && wb_sel_i[0];
    wire logic [7:0] idx = wb_adr_i[9:2];
    property p_ack_next; take |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper bits set");
    property p_force; wr && idx == 8'h55 && wb_dat_i[2] |-> ##[1:3] timeout_pulse; endproperty
    a_force: assert property (p_force) else $error("force gave no timeout");
    // Skip two cycles: an expiry already in flight may still land
    property p_zero; wr && idx == 8'h53 && wb_dat_i[7:0] == 8'h00 |-> ##3 !timeout_pulse[*5];
    endproperty
    a_zero: assert property (p_zero) else $error("timeout while disabled");
    property p_pulse_once; timeout_pulse |=> !timeout_pulse; endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("pulse too long");
    property p_lines;
        !$stable(irq_lines) |-> $past(timeout_pulse) || $past(timeout_pulse, 2)
            || $past(timeout_pulse, 3) || $past(wb_ack_o) || $past(wb_ack_o, 2);
    endproperty
    a_lines: assert property (p_lines) else $error("irq lines moved alone");
    property p_irq;
        $rose(irq) |-> $past(timeout_pulse) || $past(timeout_pulse, 2)
            || $past(timeout_pulse, 3) || $past(wb_ack_o) || $past(wb_ack_o, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("irq rose alone");
    c_tmo: cover property (timeout_pulse);
    c_irq: cover property ($rose(irq));
    c_wr: cover property (wb_ack_o && wb_we_i);
endmodule // swt_chk
bind swt_watchdog swt_chk swt_chk_i (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .irq_lines, .timeout_pulse, .irq);
`default_nettype wire

// ==== verification/test_system_watchdog_timer.sv ====
// Self-checking bench for the system watchdog
`timescale 1ns/10ps
`default_nettype none
`include "swt_defs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_system_watchdog_timer;
    localparam int P = 4;
    logic clk = 0;
    logic rstn = 0;
    logic wcyc = 0;
    logic wstb = 0;
    logic we = 0;
    logic [31:0] adr = 0;
    logic [31:0] dat = 0;
    logic [2:0] src = 0;
    logic [15:0] ioa = `SWT_GAME_PORT;
    wire [31:0] rdat;
    wire [15:0] lines;
    wire ack;
    wire tp;
    wire irq_o;
    int error_cnt = 0;
    int n_checks = 0;
    int tmo_cnt = 0;
    logic [7:0] r;
    int t;
    swt_watchdog #(.SEC_CYCLES(P)) swt_watchdog_i (.clk(clk), .rstn(rstn), .wb_cyc_i(wcyc),
        .wb_stb_i(wstb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
        .wb_dat_o(rdat), .wb_ack_o(ack), .io_strobe(src[0]), .io_addr(ioa),
        .kbd_irq(src[1]), .mouse_irq(src[2]), .irq_lines(lines), .timeout_pulse(tp),
        .irq(irq_o));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) if (tp === 1'b1) tmo_cnt <= tmo_cnt + 1;
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int k = 0;
        @(posedge clk);
        wcyc <= 1;
        wstb <= 1;
        we <= w;
        adr <= {22'h0, i, 2'b00};
        dat <= {24'h0, d};
        do
        begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        r = rdat[7:0];
        wcyc <= 0;
        wstb <= 0;
        if (ack !== 1'b1)
        begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        wb(0, i, 8'h00);
        `CHK("register", e, r)
    endtask
    // Cycles from the launching ack to the pulse
    task automatic wait_pulse(input int lim);
        t = 0;
        do
        begin
            @(posedge clk);
            t++;
        end while (tp !== 1'b1 && t < lim);
        if (tp !== 1'b1)
        begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic s_time(input logic [7:0] u, input logic [7:0] n, input int e);
        wb(1, 8'h52, u);
        wb(1, 8'h53, n);
        wait_pulse(e + 20);
        `CHK("expiry time", 1'b1, t >= e - 1 && t <= e + 3)
    endtask
    // Four source edges, 6 cycles apart, inside an 8-cycle timeout
    task automatic s_reload(input int s, input logic en, input logic [15:0] a);
        int c0;
        ioa <= a;
        wb(1, 8'h54, 8'(en) << s);
        wb(1, 8'h53, 8'h02);
        c0 = tmo_cnt;
        repeat (4)
        begin
            src[s] <= 1;
            repeat (3) @(posedge clk);
            src[s] <= 0;
            repeat (3) @(posedge clk);
        end
        `CHK("reload", c0 + int'(!en || a != `SWT_GAME_PORT), tmo_cnt)
        if (tmo_cnt == c0)
            wait_pulse(20);
        ioa <= `SWT_GAME_PORT;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1;
        rdc(8'h52, `SWT_RST_UNIT);
        rdc(8'h53, `SWT_RST_COUNT);
        rdc(8'h54, `SWT_RST_RELOAD);
        wb(1, 8'h70, 8'hFF);
        rdc(8'h70, 8'h00);
        wb(1, 8'h54, 8'h40);
        wb(1, 8'h61, 8'h01);
        wb(1, 8'h55, 8'h04);
        rdc(8'h55, 8'h01);
        `CHK("irq lines", 16'h0010, lines)
        `CHK("irq", 1'b1, irq_o)
        wb(1, 8'h60, 8'h01);
        wb(1, 8'h55, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("irq clear", 1'b0, irq_o)
        `CHK("lines clear", 16'h0000, lines)
        wb(1, 8'h54, 8'h20);
        wb(1, 8'h55, 8'h04);
        repeat (2) @(posedge clk);
        `CHK("invalid map", 16'h0000, lines)
        s_time(8'h80, 8'h01, P);
        s_time(8'h80, 8'hFF, 255 * P);
        s_time(8'h00, 8'h02, 120 * P);
        wb(1, 8'h52, 8'h80);
        wb(1, 8'h55, 8'h00);
        wb(1, 8'h53, 8'h02);
        rdc(8'h55, 8'h00);
        wb(1, 8'h53, 8'h00);
        t = tmo_cnt;
        repeat (4 * P) @(posedge clk);
        `CHK("disabled", t, tmo_cnt)
        for (int s = 0; s < 3; s++)
        begin
            s_reload(s, 1'b0, `SWT_GAME_PORT);
            s_reload(s, 1'b1, `SWT_GAME_PORT);
        end
        s_reload(0, 1'b1, 16'h0202);
        report_and_stop();
    end
endmodule // test_system_watchdog_timer
`default_nettype wire
